/* src/apig_pkg.sv */
// Package for the auxiliary-pointer indirect address generator.
package apig_pkg;

  // ----------------------------------------------------------------
  // Widths and constants
  // ----------------------------------------------------------------
  localparam int unsigned PTR_W          = 16;
  localparam int unsigned NUM_PTR        = 8;
  localparam int unsigned PTR_IDX_W      = 3;
  localparam int unsigned SHORT_W        = 3;
  localparam logic [2:0]  SHORT_MIN      = 3'h1;
  localparam logic [15:0] STEP_ONE       = 16'h0001;
  localparam logic [15:0] STEP_TWO       = 16'h0002;
  localparam logic [15:0] PTR_RST        = 16'h0000;
  localparam logic [2:0]  PTR_ZERO_IDX   = 3'h0;
  localparam int unsigned EXT_BYTES      = 2;

  // ----------------------------------------------------------------
  // Operand kinds
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    APIG_OP_PLAIN     = 4'b0000,
    APIG_OP_POST_INC  = 4'b0001,
    APIG_OP_POST_DEC  = 4'b0010,
    APIG_OP_POST_ADD  = 4'b0011,
    APIG_OP_POST_SUB  = 4'b0100,
    APIG_OP_INDEXED   = 4'b0101,
    APIG_OP_LONG_IDX  = 4'b0110,
    APIG_OP_PRE_LONG  = 4'b0111,
    APIG_OP_SHORT_IDX = 4'b1000
  } apig_op_e;

  // Access spaces.
  typedef enum logic [1:0] {
    APIG_SP_DATA = 2'b00,
    APIG_SP_MMR  = 2'b01,
    APIG_SP_BIT  = 2'b10,
    APIG_SP_IO   = 2'b11
  } apig_space_e;

  // Access size.
  typedef enum logic [1:0] {
    APIG_SZ_WORD   = 2'b00,
    APIG_SZ_DWORD  = 2'b01,
    APIG_SZ_BIT    = 2'b10,
    APIG_SZ_BITPR  = 2'b11
  } apig_size_e;

  // Operand request from the decoder.
  typedef struct packed {
    apig_op_e          op;
    apig_space_e       space;
    apig_size_e        size;
    logic [2:0]        ptr_idx;
    logic [15:0]       long_offset_const;
    logic [2:0]        short_offset_const;
  } apig_req_s;

  // Generated address result.
  typedef struct packed {
    logic [15:0]  addr;
    apig_space_e  space;
    apig_size_e   size;
    logic         bit_pair;
  } apig_addr_s;

endpackage

/* src/apig_ptr_reg.sv */
// One auxiliary pointer register with load and update ports.
`timescale 1ns/1ps

module apig_ptr_reg
  import apig_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst,
  // Write sources
  input  wire logic        i_load,
  input  wire logic [15:0] i_load_val,
  input  wire logic        i_upd,
  input  wire logic [15:0] i_upd_val,
  // Contents
  output logic [15:0]      o_val
);

  logic [15:0] val_r;

  // Pointer update from addressing wins over a software load in the same cycle,
  // since the instruction in flight already depends on the modified value.
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
      val_r <= PTR_RST;
    else if (i_upd)
      val_r <= i_upd_val;
    else if (i_load)
      val_r <= i_load_val;
  end

  assign o_val = val_r;

endmodule // apig_ptr_reg

/* src/apig_top.sv */
// Auxiliary-pointer indirect address generator, control operand set.
// Behaviour
// - Control operand set is used only while pointer_mode_select is 1.
// - Post-subtract: address from old pointer, then subtract temp or pointer zero.
// - Indexed: pointer unchanged, address is pointer plus temp or pointer zero.
// - Long indexed: pointer unchanged, address is pointer plus signed constant.
// - Pre-add long: pointer plus constant written back, address from new value.
// - Long-constant operands need two extension bytes and never run in parallel.
// - Short indexed: pointer plus unsigned 3-bit constant; only 1 to 7 valid.
// - Post-increment adds one for word or bit, two for double or pair.
// - Post-decrement subtracts one for word or single-bit access.
// - Bit access touches one register bit; bit-pair touches two adjacent bits.
`timescale 1ns/1ps

module apig_top
  import apig_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst,
  // Status bits
  input  wire logic        i_pointer_mode_select,
  input  wire logic        i_legacy_compat_mode,
  // Temporary register
  input  wire logic [15:0] i_temp_reg_zero,
  // Pointer load port
  input  wire logic        i_ptr_load,
  input  wire logic [2:0]  i_ptr_load_idx,
  input  wire logic [15:0] i_ptr_load_val,
  // Operand request
  input  wire logic        i_req_valid,
  input  wire apig_req_s   i_req,
  input  wire logic        i_req_parallel,
  // Result
  output logic             o_addr_valid,
  output apig_addr_s       o_addr,
  output logic             o_illegal,
  output logic             o_serialize,
  output logic [1:0]       o_ext_bytes,
  output logic [127:0]     o_aux_pointer
);

  // ----------------------------------------------------------------
  // Pointer file
  // ----------------------------------------------------------------
  logic [15:0] ptr_val [NUM_PTR];
  logic [15:0] upd_val;
  logic        upd_en;

  // Pointer arithmetic wraps at 16 bits; code that relies on the wrap is unsupported.
  // An addressing update takes priority over a load inside each register.
  genvar g;
  generate
    for (g = 0; g < NUM_PTR; g++)
    begin : g_ptr
      apig_ptr_reg u_ptr (
        .i_clk_sys  (i_clk_sys),
        .i_rst      (i_rst),
        .i_load     (i_ptr_load && (i_ptr_load_idx == 3'(g))),
        .i_load_val (i_ptr_load_val),
        .i_upd      (upd_en && (i_req.ptr_idx == 3'(g))),
        .i_upd_val  (upd_val),
        .o_val      (ptr_val[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Operand decode
  // ----------------------------------------------------------------
  logic [15:0] aux_pointer;
  logic [15:0] aux_pointer_zero;
  logic [15:0] reg_offset;
  logic [15:0] addr_nxt;
  logic        long_op;
  logic        illegal_nxt;
  logic [15:0] step;

  assign aux_pointer      = ptr_val[i_req.ptr_idx];
  assign aux_pointer_zero = ptr_val[PTR_ZERO_IDX];

  // The compatibility bit picks the offset register for the indexed
  // form and for the post-add and post-subtract forms.
  assign reg_offset = i_legacy_compat_mode ? aux_pointer_zero
                                           : i_temp_reg_zero;

  assign long_op = (i_req.op == APIG_OP_LONG_IDX) || (i_req.op == APIG_OP_PRE_LONG);

  // Double words and bit pairs step by two.
  assign step = ((i_req.size == APIG_SZ_DWORD) || (i_req.size == APIG_SZ_BITPR))
                ? STEP_TWO : STEP_ONE;

  always_comb
  begin
    addr_nxt = aux_pointer;
    upd_val  = aux_pointer;
    upd_en   = 1'b0;
    case (i_req.op)
      APIG_OP_PLAIN:
      begin
        addr_nxt = aux_pointer;
      end
      APIG_OP_POST_INC:
      begin
        upd_val = aux_pointer + step;
        upd_en  = 1'b1;
      end
      APIG_OP_POST_DEC:
      begin
        upd_val = aux_pointer - STEP_ONE;
        upd_en  = 1'b1;
      end
      APIG_OP_POST_ADD:
      begin
        upd_val = aux_pointer + reg_offset;
        upd_en  = 1'b1;
      end
      APIG_OP_POST_SUB:
      begin
        upd_val = aux_pointer - reg_offset;
        upd_en  = 1'b1;
      end
      APIG_OP_INDEXED:
      begin
        addr_nxt = aux_pointer + reg_offset;
      end
      APIG_OP_LONG_IDX:
      begin
        addr_nxt = aux_pointer + i_req.long_offset_const;
      end
      APIG_OP_PRE_LONG:
      begin
        // The written-back sum is also the address, so both share one adder.
        upd_val  = aux_pointer + i_req.long_offset_const;
        addr_nxt = upd_val;
        upd_en   = 1'b1;
      end
      APIG_OP_SHORT_IDX:
      begin
        addr_nxt = aux_pointer + {13'h0000, i_req.short_offset_const};
      end
      default:
      begin
        addr_nxt = aux_pointer;
      end
    endcase
    // A refused operand leaves every pointer untouched.
    if (!i_req_valid || illegal_nxt)
      upd_en = 1'b0;
  end

  // ----------------------------------------------------------------
  // Legality checks
  // ----------------------------------------------------------------
  // Each check is kept apart so that a refused operand traces to one cause.
  logic        mode_bad;
  logic        space_bad;
  logic        form_bad;
  logic        size_bad;

  // Outside the control operand set none of these forms may be decoded.
  assign mode_bad = !i_pointer_mode_select;

  // Spaces that each operand may reach; the long forms have no I/O path.
  always_comb
  begin
    space_bad = 1'b0;
    case (i_req.op)
      APIG_OP_LONG_IDX,
      APIG_OP_PRE_LONG:
      begin
        space_bad = (i_req.space == APIG_SP_IO);
      end
      default:
      begin
        space_bad = 1'b0;
      end
    endcase
  end

  // Operand forms with their own limits on encoding or pairing.
  always_comb
  begin
    form_bad = 1'b0;
    case (i_req.op)
      APIG_OP_LONG_IDX,
      APIG_OP_PRE_LONG:
      begin
        // The extension bytes take the slot that a paired instruction would use.
        form_bad = i_req_parallel;
      end
      APIG_OP_SHORT_IDX:
      begin
        form_bad = (i_req.short_offset_const < SHORT_MIN);
      end
      APIG_OP_POST_DEC:
      begin
        // Post-decrement only defines a single step, so double and pair sizes are refused.
        form_bad = (step == STEP_TWO);
      end
      APIG_OP_PLAIN,
      APIG_OP_POST_INC,
      APIG_OP_POST_ADD,
      APIG_OP_POST_SUB,
      APIG_OP_INDEXED:
      begin
        form_bad = 1'b0;
      end
      default:
      begin
        // Codes above the last operand form are reserved.
        form_bad = 1'b1;
      end
    endcase
  end

  // The bit space needs a bit or bit-pair size, and every other space a word or double-word size.
  always_comb
  begin
    size_bad = 1'b0;
    case (i_req.size)
      APIG_SZ_BIT,
      APIG_SZ_BITPR:
      begin
        size_bad = (i_req.space != APIG_SP_BIT);
      end
      default:
      begin
        size_bad = (i_req.space == APIG_SP_BIT);
      end
    endcase
  end

  // Any single failed check refuses the whole operand.
  assign illegal_nxt = mode_bad || space_bad || form_bad || size_bad;

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  // Exactly one of the two strobes answers each taken operand.
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      o_addr_valid <= 1'b0;
      o_illegal    <= 1'b0;
    end
    else
    begin
      o_addr_valid <= i_req_valid && !illegal_nxt;
      o_illegal    <= i_req_valid && illegal_nxt;
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      o_addr <= '0;
    end
    else if (i_req_valid)
    begin
      o_addr.addr     <= addr_nxt;
      o_addr.space    <= i_req.space;
      o_addr.size     <= i_req.size;
      o_addr.bit_pair <= (i_req.size == APIG_SZ_BITPR);
    end
  end

  // Extension length is reported for a refused long operand as well, so the
  // decoder can still step over its two extension bytes.
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      o_serialize <= 1'b0;
      o_ext_bytes <= 2'b00;
    end
    else if (i_req_valid)
    begin
      o_serialize <= long_op;
      o_ext_bytes <= long_op ? 2'(EXT_BYTES) : 2'b00;
    end
  end

  // Pointer snapshot, registered so it reflects the file after the update.
  // It trails the file by one cycle; a reader of a value just written waits an edge.
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
      o_aux_pointer <= '0;
    else
    begin
      for (int i = 0; i < NUM_PTR; i++)
      begin
        o_aux_pointer[i*16 +: 16] <= ptr_val[i];
      end
    end
  end

endmodule // apig_top

/* tb/apig_props.sv */
// Port checks for the auxiliary-pointer address generator.
`timescale 1ns/1ps
module apig_props
  import apig_pkg::*;
(
  // Clock, reset and inputs
  input wire logic         i_clk_sys,
  input wire logic         i_rst,
  input wire logic         i_pointer_mode_select,
  input wire logic         i_req_valid,
  input wire apig_req_s    i_req,
  input wire logic         i_req_parallel,
  // Results
  input wire logic         o_addr_valid,
  input wire apig_addr_s   o_addr,
  input wire logic         o_illegal,
  input wire logic         o_serialize,
  input wire logic [1:0]   o_ext_bytes
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  logic lng;
  assign lng = i_req.op inside {APIG_OP_LONG_IDX, APIG_OP_PRE_LONG};
  AST_MODE_OFF: assert property (i_req_valid && !i_pointer_mode_select |=> o_illegal)
    else $error("operand taken with pointer mode off");
  AST_ONE_ANSWER: assert property (i_req_valid |=> o_addr_valid != o_illegal)
    else $error("request without exactly one answer");
  AST_IDLE: assert property (!i_req_valid |=> !o_addr_valid && !o_illegal)
    else $error("answer without request");
  AST_LONG_EXT: assert property (
      i_req_valid && lng |=> o_addr_valid |-> o_ext_bytes == 2'h2 && o_serialize)
    else $error("long operand without extension");
  AST_SHORT_EXT: assert property (
      i_req_valid && !lng |=> o_addr_valid |-> o_ext_bytes == 2'h0)
    else $error("extension bytes on plain operand");
  AST_LONG_PAR: assert property (i_req_valid && lng && i_req_parallel |=> o_illegal)
    else $error("long operand run in parallel");
  AST_LONG_IO: assert property (
      i_req_valid && lng && i_req.space == APIG_SP_IO |=> o_illegal)
    else $error("long operand reached io space");
  AST_SHORT_ZERO: assert property (
      i_req_valid && i_req.op == APIG_OP_SHORT_IDX && i_req.short_offset_const == 3'h0
      |=> o_illegal)
    else $error("short constant zero accepted");
  AST_DEC_WIDE: assert property (
      i_req_valid && i_req.op == APIG_OP_POST_DEC &&
      i_req.size inside {APIG_SZ_DWORD, APIG_SZ_BITPR} |=> o_illegal)
    else $error("wide post decrement accepted");
  AST_PAIR: assert property (
      i_req_valid && i_req.size == APIG_SZ_BITPR |=> o_addr_valid |-> o_addr.bit_pair)
    else $error("bit pair not flagged");
  AST_BIT_SPACE: assert property (
      i_req_valid && ((i_req.space == APIG_SP_BIT) !=
      (i_req.size inside {APIG_SZ_BIT, APIG_SZ_BITPR})) |=> o_illegal)
    else $error("bit space and size mismatch accepted");
  AST_SHORT_OK: assert property (
      i_req_valid && i_pointer_mode_select && i_req.op == APIG_OP_SHORT_IDX &&
      i_req.short_offset_const != 3'h0 && i_req.space != APIG_SP_BIT &&
      i_req.size == APIG_SZ_WORD |=> o_addr_valid)
    else $error("valid short operand refused");
  cover property (i_req_valid && lng ##1 o_addr_valid);
  cover property (o_illegal);
  cover property (i_req_valid [*2]);
  cover property (o_addr_valid && o_addr.bit_pair);
endmodule // apig_props

/* tb/apig_bus_model.sv */
// Data, register and io bus responder that records each access.
`timescale 1ns/1ps
module apig_bus_model
  import apig_pkg::*;
(
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst,
  input  wire logic        i_valid,
  input  wire apig_addr_s  i_addr,
  output logic [15:0]      o_last_addr
);
  // Every space is served, io included, so the block alone must guard it.
  always_ff @(posedge i_clk_sys)
    if (i_rst)
      o_last_addr <= 16'h0000;
    else if (i_valid)
      o_last_addr <= i_addr.addr;
endmodule // apig_bus_model

/* tb/testbench.sv */
// Self-checking bench for the auxiliary-pointer address generator.
`timescale 1ns/1ps
module testbench;
  import apig_pkg::*;
  typedef struct {logic [3:0] op; logic [1:0] sp; logic [1:0] sz; logic [15:0] k;
                  logic par; logic il; logic [15:0] ad; logic [15:0] pt;} apig_tb_row_s;
  logic i_clk_sys = 0, i_rst = 1, i_pointer_mode_select = 1, i_legacy_compat_mode = 0;
  logic i_ptr_load = 0, i_req_valid = 0, i_req_parallel = 0, o_addr_valid, o_illegal;
  logic o_serialize;
  logic [15:0] i_temp_reg_zero = 16'h0010, i_ptr_load_val = 0, seen;
  logic [2:0] i_ptr_load_idx = 0;
  logic [1:0] o_ext_bytes;
  logic [127:0] o_aux_pointer;
  apig_req_s i_req = '0;
  apig_addr_s o_addr;
  int num_errors = 0, total_checks = 0;
  apig_tb_row_s rows [18] = '{
    '{0,0,0,16'h0000,0,0,16'h1000,16'h1000}, '{1,0,0,16'h0000,0,0,16'h1000,16'h1001},
    '{1,1,1,16'h0000,0,0,16'h1000,16'h1002}, '{1,2,3,16'h0000,0,0,16'h1000,16'h1002},
    '{2,2,2,16'h0000,0,0,16'h1000,16'h0FFF}, '{3,0,0,16'h0000,0,0,16'h1000,16'h1010},
    '{4,0,0,16'h0000,0,0,16'h1000,16'h0FF0}, '{5,3,0,16'h0000,0,0,16'h1010,16'h1000},
    '{6,1,0,16'hFFF0,0,0,16'h0FF0,16'h1000}, '{7,0,0,16'h0005,0,0,16'h1005,16'h1005},
    '{8,3,0,16'h0007,0,0,16'h1007,16'h1000}, '{8,0,0,16'h0000,0,1,16'h0000,16'h1000},
    '{2,0,1,16'h0000,0,1,16'h0000,16'h1000}, '{6,3,0,16'h0000,0,1,16'h0000,16'h1000},
    '{7,0,0,16'h0005,1,1,16'h0000,16'h1000}, '{9,0,0,16'h0000,0,1,16'h0000,16'h1000},
    '{0,2,0,16'h0000,0,1,16'h0000,16'h1000}, '{1,0,2,16'h0000,0,1,16'h0000,16'h1000}};
  apig_top i_apig_top (.i_clk_sys, .i_rst, .i_pointer_mode_select, .i_legacy_compat_mode,
    .i_temp_reg_zero, .i_ptr_load, .i_ptr_load_idx, .i_ptr_load_val, .i_req_valid, .i_req,
    .i_req_parallel, .o_addr_valid, .o_addr, .o_illegal, .o_serialize, .o_ext_bytes,
    .o_aux_pointer);
  apig_bus_model i_apig_bus_model (.i_clk_sys, .i_rst, .i_valid(o_addr_valid), .i_addr(o_addr),
    .o_last_addr(seen));
  always #5 i_clk_sys = ~i_clk_sys;
  task automatic chk(string n, logic [15:0] e, logic [15:0] s);
    total_checks++;
    if (s !== e)
    begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic ldp(logic [2:0] x, logic [15:0] v);
    @(negedge i_clk_sys);
    {i_ptr_load, i_ptr_load_idx, i_ptr_load_val} = {1'b1, x, v};
    @(negedge i_clk_sys);
    i_ptr_load = 0;
  endtask
  // Result is looked at just after the one-cycle valid pulse drops, while the registered answer stands.
  task automatic send(logic [3:0] op, logic [1:0] sp, logic [1:0] sz, logic [15:0] k, logic p);
    @(negedge i_clk_sys);
    i_req = '{apig_op_e'(op), apig_space_e'(sp), apig_size_e'(sz), 3'h1, k, k[2:0]};
    {i_req_valid, i_req_parallel} = {1'b1, p};
    @(negedge i_clk_sys);
    i_req_valid = 0;
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    #50000;
    num_errors++;
    give_verdict();
  end
  initial
  begin
    repeat (20) @(negedge i_clk_sys);
    i_rst = 0;
    chk("reset ptr", 16'h0000, o_aux_pointer[31:16]);
    foreach (rows[j])
    begin
      ldp(3'h1, 16'h1000);
      send(rows[j].op, rows[j].sp, rows[j].sz, rows[j].k, rows[j].par);
      chk("illegal", {15'h0, rows[j].il}, {15'h0, o_illegal});
      chk("addr valid", {15'h0, !rows[j].il}, {15'h0, o_addr_valid});
      chk("ext", 16'(rows[j].op inside {6, 7}) * 16'(EXT_BYTES), {14'h0, o_ext_bytes});
      chk("serialize", 16'(rows[j].op inside {6, 7}), {15'h0, o_serialize});
      if (!rows[j].il)
        chk("addr", rows[j].ad, o_addr.addr);
      @(negedge i_clk_sys);
      chk("ptr", rows[j].pt, o_aux_pointer[31:16]);
    end
    i_legacy_compat_mode = 1;
    ldp(3'h0, 16'hFFFE);
    ldp(3'h1, 16'h0100);
    send(4'h5, 2'h0, 2'h0, 16'h0000, 1'b0);
    chk("legacy addr", 16'h00FE, o_addr.addr);
    send(4'h4, 2'h0, 2'h0, 16'h0000, 1'b0);
    @(negedge i_clk_sys);
    chk("legacy ptr", 16'h0102, o_aux_pointer[31:16]);
    @(negedge i_clk_sys);
    i_req = '{APIG_OP_POST_INC, APIG_SP_DATA, APIG_SZ_WORD, 3'h1, 16'h0000, 3'h0};
    i_req_valid = 1;
    repeat (2) @(negedge i_clk_sys);
    i_req_valid = 0;
    @(negedge i_clk_sys);
    chk("b2b ptr", 16'h0104, o_aux_pointer[31:16]);
    chk("bus addr", 16'h0103, seen);
    i_pointer_mode_select = 0;
    send(4'h0, 2'h0, 2'h0, 16'h0000, 1'b0);
    chk("mode off", 16'h0001, {15'h0, o_illegal});
    // Reset again in mid-run, then check that the block clears and resumes.
    @(negedge i_clk_sys);
    i_rst = 1;
    repeat (2) @(negedge i_clk_sys);
    i_rst = 0;
    chk("rerun ptr", 16'h0000, o_aux_pointer[31:16]);
    chk("rerun addr", 16'h0000, o_addr.addr);
    i_pointer_mode_select = 1;
    ldp(3'h1, 16'h2000);
    send(4'h1, 2'h0, 2'h0, 16'h0000, 1'b0);
    chk("resume addr", 16'h2000, o_addr.addr);
    @(negedge i_clk_sys);
    chk("resume ptr", 16'h2001, o_aux_pointer[31:16]);
    give_verdict();
  end
endmodule // testbench
bind apig_top apig_props i_apig_props (.i_clk_sys, .i_rst, .i_pointer_mode_select, .i_req_valid,
  .i_req, .i_req_parallel, .o_addr_valid, .o_addr, .o_illegal, .o_serialize, .o_ext_bytes);
